// File: src/dsos_defines.vh
// Purpose: constants of the drive status output selector
// Assumes: included by bare name from dsos_status_select.v
// Notes: register offsets are word indices on the plain register port
`ifndef DSOS_DEFINES_VH
`define DSOS_DEFINES_VH

// ====================================================================
// register offsets
`define DSOS_ADDR_W 8
`define DSOS_DATA_W 16
`define DSOS_OFS_SEL_BASE 8'h00
`define DSOS_OFS_THERM_MODE 8'h10
`define DSOS_OFS_FDT_LEVEL 8'h11
`define DSOS_OFS_FDT_HYST 8'h12
`define DSOS_OFS_FAR_HYST 8'h13
`define DSOS_OFS_RUN_PRESET 8'h14
`define DSOS_OFS_START_PRESET 8'h15
`define DSOS_OFS_STATUS 8'h16

// ====================================================================
// reset values
`define DSOS_RST_SEL 8'h00
`define DSOS_RST_THERM_MODE 2'h0
`define DSOS_RST_FDT_LEVEL 16'h0258
`define DSOS_RST_FDT_HYST 16'h0000
`define DSOS_RST_FAR_HYST 16'h0019
`define DSOS_RST_PRESET 16'hFFFF

// ====================================================================
// status register field positions
`define DSOS_ST_FAULT 0
`define DSOS_ST_OFF 1
`define DSOS_ST_TRIP 2
`define DSOS_ST_CUTOFF 3
`define DSOS_ST_FAR 4
`define DSOS_ST_FDT 5
`define DSOS_ST_SERVICE 6
`define DSOS_ST_THERM_TRIP 7

// ====================================================================
// thermistor modes and measurement limits
`define DSOS_THERM_TRIP_MODE 2'h1
`define DSOS_THERM_WARN_MODE 2'h2
`define DSOS_WIRE_BREAK_UA 16'h07D0

// ====================================================================
// selector codes
`define DSOS_SEL_RUN_ACC 8'h37
`define DSOS_SEL_THERM 8'h38
`define DSOS_SEL_WIRE 8'h3B
`define DSOS_SEL_SERVICE 8'h54
`define DSOS_SEL_SPEED_REACHED_AND_DETECTED 8'h57
`define DSOS_SEL_EMERG 8'h5F
`define DSOS_SEL_MINOR 8'h62
`define DSOS_SEL_ANY 8'h63
`define DSOS_SEL_EN_FAULT 8'h65
`define DSOS_SEL_EN_OFF 8'h66
`define DSOS_SEL_TMR_CANCEL 8'hBE
`define DSOS_SEL_TMR_A 8'hBF
`define DSOS_SEL_TMR_B 8'hC0
`define DSOS_SEL_TMR_C 8'hC1
`define DSOS_SEL_TMR_D 8'hC2
`define DSOS_SEL_LOOP2 8'hC8
`define DSOS_SEL_LA_ALM 8'hC9
`define DSOS_SEL_LA_FB 8'hCA
`define DSOS_SEL_LB_ALM 8'hCB
`define DSOS_SEL_LB_FB 8'hCC
`define DSOS_SEL_X1_SEL 8'hD3
`define DSOS_SEL_X1_DUTY 8'hD4
`define DSOS_SEL_X1_RUN 8'hD5
`define DSOS_SEL_X1_ALM 8'hD6
`define DSOS_SEL_X1_FB 8'hD7
`define DSOS_SEL_X2_SEL 8'hDD
`define DSOS_SEL_X2_DUTY 8'hDE
`define DSOS_SEL_X2_RUN 8'hDF
`define DSOS_SEL_X2_ALM 8'hE0
`define DSOS_SEL_X2_FB 8'hE1
`define DSOS_SEL_X3_SEL 8'hE7
`define DSOS_SEL_X3_DUTY 8'hE8
`define DSOS_SEL_X3_RUN 8'hE9
`define DSOS_SEL_X3_ALM 8'hEA
`define DSOS_SEL_X3_FB 8'hEB

// ====================================================================
// timing
`define DSOS_CLK_HZ 20000000
`define DSOS_MISMATCH_MS 50
`define DSOS_MISMATCH_CYC (`DSOS_MISMATCH_MS * (`DSOS_CLK_HZ / 1000))

`endif

// File: src/dsos_status_select.v
// Purpose: drive status flags routed to output terminals by selector code
// Assumes: status inputs come from drive logic on ref_clk_i; the safety
//   enable and mains-present pins are asynchronous
// Notes: resetn_i is the full drive restart
// Operation
// - selector 55: run-accepted flag once ready to run after run command
// - selector 56, thermistor mode 2: overheat sets flag, no trip
// - selector 59: wire-break flag when current input below 2 mA
// - selector 84: service due when run time or start count exceeds preset
// - selector 87: arrival AND detected
// - selector 95: emergency-run flag in fire mode
// - selector 98: minor-fault flag on light alarm
// - selector 99: any-fault flag in alarm mode
// - selector 101: enable-path-fault flag on enable monitor error
// - selector 102: with power, both enables off gives off flag, fault only if tripped, shutdown
// - power and both enables on: flags off unless tripped; exactly one on: fault, shutdown
// - mismatch trip only after enables disagree longer than 50 ms
// - mismatch trip latched until full restart
// - selectors 190-194 timer flags, all off if timers disabled or invalid
// - selector 200: second PID loop selected
// - selectors 201-204: loop alarms and feedback errors
// - selectors 211/221/231: external loop selected
// - selectors 212/222/232: external loop duty output
// - selectors 213/223/233: external loop running
// - 214/224/234 alarm while selected; 215/225/235 feedback error
// - detected flag: set above level, clear below level minus hysteresis
// - arrival forced off when run off or reference zero
`timescale 1ns/100ps
`include "dsos_defines.vh"

module dsos_status_select #(
  parameter NUM_TERM = 5,
  parameter MISMATCH_CYC = `DSOS_MISMATCH_CYC
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire [`DSOS_ADDR_W-1:0] reg_addr_i,
  input wire [`DSOS_DATA_W-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [`DSOS_DATA_W-1:0] reg_rdata_o,
  input wire main_power_i,
  input wire safety_enable_a_i,
  input wire safety_enable_b_i,
  input wire run_cmd_i,
  input wire ready_to_run_i,
  input wire motor_overheat_i,
  input wire [15:0] current_input_ua_i,
  input wire [15:0] run_time_i,
  input wire [15:0] start_count_i,
  input wire [15:0] out_freq_i,
  input wire [15:0] ref_freq_i,
  input wire fire_mode_i,
  input wire light_alarm_i,
  input wire alarm_mode_i,
  input wire timer_op_ok_i,
  input wire timer_cancel_i,
  input wire [3:0] timer_active_i,
  input wire second_loop_selected_i,
  input wire [1:0] loop_alarm_i,
  input wire [1:0] loop_feedback_err_i,
  input wire [2:0] ext_loop_selected_i,
  input wire [2:0] ext_loop_duty_out_i,
  input wire [2:0] ext_loop_running_i,
  input wire [2:0] ext_loop_alarm_i,
  input wire [2:0] ext_loop_feedback_err_i,
  output reg [NUM_TERM-1:0] term_o,
  output reg torque_cutoff_o,
  output reg thermistor_trip_o,
  output reg enable_mismatch_trip_o
);

  // ==================================================================
  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  reg [2:0] pin_s1_q;
  reg [2:0] pin_s2_q;
  reg [2:0] pin_s3_q;
  reg [2:0] pin_q;
  wire [2:0] pin_raw;
  wire pw_ok;
  wire en_a;
  wire en_b;

  assign pin_raw = {main_power_i, safety_enable_b_i, safety_enable_a_i};

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  assign en_a = pin_q[0];
  assign en_b = pin_q[1];
  assign pw_ok = pin_q[2];

  // ==================================================================
  // configuration registers
  reg [7:0] sel_q [0:NUM_TERM-1];
  reg [1:0] therm_mode_q;
  reg [15:0] fdt_level_q;
  reg [15:0] fdt_hyst_q;
  reg [15:0] far_hyst_q;
  reg [15:0] run_preset_q;
  reg [15:0] start_preset_q;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      therm_mode_q <= `DSOS_RST_THERM_MODE;
      fdt_level_q <= `DSOS_RST_FDT_LEVEL;
      fdt_hyst_q <= `DSOS_RST_FDT_HYST;
      far_hyst_q <= `DSOS_RST_FAR_HYST;
      run_preset_q <= `DSOS_RST_PRESET;
      start_preset_q <= `DSOS_RST_PRESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `DSOS_OFS_THERM_MODE: therm_mode_q <= reg_wdata_i[1:0];
        `DSOS_OFS_FDT_LEVEL: fdt_level_q <= reg_wdata_i;
        `DSOS_OFS_FDT_HYST: fdt_hyst_q <= reg_wdata_i;
        `DSOS_OFS_FAR_HYST: far_hyst_q <= reg_wdata_i;
        `DSOS_OFS_RUN_PRESET: run_preset_q <= reg_wdata_i;
        `DSOS_OFS_START_PRESET: start_preset_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ==================================================================
  // safety enable monitor
  reg [19:0] mis_cnt_q;
  reg trip_q;
  wire mismatch;
  wire en_fault;
  wire en_off;

  assign mismatch = en_a ^ en_b;
  assign en_fault = pw_ok & (mismatch | trip_q);
  assign en_off = pw_ok & ~en_a & ~en_b;

  // the count restarts on any agreement, so only an unbroken mismatch trips
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mis_cnt_q <= 20'h00000;
      trip_q <= 1'b0;
    end else begin
      if (!mismatch || !pw_ok)
        mis_cnt_q <= 20'h00000;
      else if (mis_cnt_q != MISMATCH_CYC[19:0])
        mis_cnt_q <= mis_cnt_q + 20'h00001;
      if (pw_ok && mismatch && mis_cnt_q == MISMATCH_CYC[19:0])
        trip_q <= 1'b1;
      // no clear path: only resetn_i (full restart) drops the trip
    end
  end

  // ==================================================================
  // frequency detection and arrival
  reg fdt_q;
  wire [16:0] fdt_low;
  wire [15:0] freq_diff;
  wire freq_arrival;

  assign fdt_low = {1'b0, fdt_level_q} - {1'b0, fdt_hyst_q};

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fdt_q <= 1'b0;
    end else if (out_freq_i > fdt_level_q) begin
      fdt_q <= 1'b1;
    end else if (!fdt_low[16] && out_freq_i < fdt_low[15:0]) begin
      fdt_q <= 1'b0;
    end
  end

  assign freq_diff = (out_freq_i > ref_freq_i) ? (out_freq_i - ref_freq_i)
                                               : (ref_freq_i - out_freq_i);
  assign freq_arrival = run_cmd_i & (ref_freq_i != 16'h0000) & (freq_diff <= far_hyst_q);

  // ==================================================================
  // derived flags
  wire therm_flag;
  wire wire_break;
  wire service_due;
  wire speed_reached_and_detected;
  wire tmr_ok;
  wire cutoff;

  assign therm_flag = motor_overheat_i & (therm_mode_q == `DSOS_THERM_WARN_MODE);
  assign wire_break = current_input_ua_i < `DSOS_WIRE_BREAK_UA;
  assign service_due = (run_time_i > run_preset_q) | (start_count_i > start_preset_q);
  assign speed_reached_and_detected = freq_arrival & fdt_q;
  assign tmr_ok = timer_op_ok_i;
  assign cutoff = ~pw_ok | ~en_a | ~en_b | trip_q;

  // ==================================================================
  // terminal selectors
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi = gi + 1) begin : g_term
      reg flag;

      always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i)
          sel_q[gi] <= `DSOS_RST_SEL;
        else if (reg_wr_i && reg_addr_i == `DSOS_OFS_SEL_BASE + gi)
          sel_q[gi] <= reg_wdata_i[7:0];
      end

      always @* begin
        case (sel_q[gi])
          `DSOS_SEL_RUN_ACC: flag = run_cmd_i & ready_to_run_i;
          `DSOS_SEL_THERM: flag = therm_flag;
          `DSOS_SEL_WIRE: flag = wire_break;
          `DSOS_SEL_SERVICE: flag = service_due;
          `DSOS_SEL_SPEED_REACHED_AND_DETECTED: flag = speed_reached_and_detected;
          `DSOS_SEL_EMERG: flag = fire_mode_i;
          `DSOS_SEL_MINOR: flag = light_alarm_i;
          `DSOS_SEL_ANY: flag = alarm_mode_i;
          `DSOS_SEL_EN_FAULT: flag = en_fault;
          `DSOS_SEL_EN_OFF: flag = en_off;
          `DSOS_SEL_TMR_CANCEL: flag = tmr_ok & timer_cancel_i;
          `DSOS_SEL_TMR_A: flag = tmr_ok & timer_active_i[0];
          `DSOS_SEL_TMR_B: flag = tmr_ok & timer_active_i[1];
          `DSOS_SEL_TMR_C: flag = tmr_ok & timer_active_i[2];
          `DSOS_SEL_TMR_D: flag = tmr_ok & timer_active_i[3];
          `DSOS_SEL_LOOP2: flag = second_loop_selected_i;
          `DSOS_SEL_LA_ALM: flag = loop_alarm_i[0];
          `DSOS_SEL_LA_FB: flag = loop_feedback_err_i[0];
          `DSOS_SEL_LB_ALM: flag = loop_alarm_i[1];
          `DSOS_SEL_LB_FB: flag = loop_feedback_err_i[1];
          `DSOS_SEL_X1_SEL: flag = ext_loop_selected_i[0];
          `DSOS_SEL_X2_SEL: flag = ext_loop_selected_i[1];
          `DSOS_SEL_X3_SEL: flag = ext_loop_selected_i[2];
          `DSOS_SEL_X1_DUTY: flag = ext_loop_duty_out_i[0];
          `DSOS_SEL_X2_DUTY: flag = ext_loop_duty_out_i[1];
          `DSOS_SEL_X3_DUTY: flag = ext_loop_duty_out_i[2];
          `DSOS_SEL_X1_RUN: flag = ext_loop_running_i[0];
          `DSOS_SEL_X2_RUN: flag = ext_loop_running_i[1];
          `DSOS_SEL_X3_RUN: flag = ext_loop_running_i[2];
          `DSOS_SEL_X1_ALM: flag = ext_loop_alarm_i[0] & ext_loop_selected_i[0];
          `DSOS_SEL_X2_ALM: flag = ext_loop_alarm_i[1] & ext_loop_selected_i[1];
          `DSOS_SEL_X3_ALM: flag = ext_loop_alarm_i[2] & ext_loop_selected_i[2];
          `DSOS_SEL_X1_FB: flag = ext_loop_feedback_err_i[0] & ext_loop_selected_i[0];
          `DSOS_SEL_X2_FB: flag = ext_loop_feedback_err_i[1] & ext_loop_selected_i[1];
          `DSOS_SEL_X3_FB: flag = ext_loop_feedback_err_i[2] & ext_loop_selected_i[2];
          default: flag = 1'b0;
        endcase
      end

      // positive logic here; safety wiring inverts at the terminal driver
      always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i)
          term_o[gi] <= 1'b0;
        else
          term_o[gi] <= flag;
      end
    end
  endgenerate

  // ==================================================================
  // drive outputs and register read
  reg [`DSOS_DATA_W-1:0] status;

  always @* begin
    status = {`DSOS_DATA_W{1'b0}};
    status[`DSOS_ST_FAULT] = en_fault;
    status[`DSOS_ST_OFF] = en_off;
    status[`DSOS_ST_TRIP] = trip_q;
    status[`DSOS_ST_CUTOFF] = cutoff;
    status[`DSOS_ST_FAR] = freq_arrival;
    status[`DSOS_ST_FDT] = fdt_q;
    status[`DSOS_ST_SERVICE] = service_due;
    status[`DSOS_ST_THERM_TRIP] = thermistor_trip_o;
  end

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      torque_cutoff_o <= 1'b1;
      thermistor_trip_o <= 1'b0;
      enable_mismatch_trip_o <= 1'b0;
      reg_rdata_o <= {`DSOS_DATA_W{1'b0}};
    end else begin
      torque_cutoff_o <= cutoff;
      // mode 2 only warns, so the trip state follows mode 1 alone
      thermistor_trip_o <= motor_overheat_i &
                           (therm_mode_q == `DSOS_THERM_TRIP_MODE);
      enable_mismatch_trip_o <= trip_q;
      reg_rdata_o <= {`DSOS_DATA_W{1'b0}};
      if (reg_rd_i) begin
        if (reg_addr_i < NUM_TERM)
          reg_rdata_o <= {8'h00, sel_q[reg_addr_i[2:0]]};
        else begin
          case (reg_addr_i)
            `DSOS_OFS_THERM_MODE: reg_rdata_o <= {14'h0000, therm_mode_q};
            `DSOS_OFS_FDT_LEVEL: reg_rdata_o <= fdt_level_q;
            `DSOS_OFS_FDT_HYST: reg_rdata_o <= fdt_hyst_q;
            `DSOS_OFS_FAR_HYST: reg_rdata_o <= far_hyst_q;
            `DSOS_OFS_RUN_PRESET: reg_rdata_o <= run_preset_q;
            `DSOS_OFS_START_PRESET: reg_rdata_o <= start_preset_q;
            `DSOS_OFS_STATUS: reg_rdata_o <= status;
            default: reg_rdata_o <= {`DSOS_DATA_W{1'b0}};
          endcase
        end
      end
    end
  end

endmodule // dsos_status_select

// File: testbench/dsos_relay_model.sv
// Purpose: safety relay reading the enable-monitor terminals
// Assumes: fault flag on terminal 0, enables-off flag on terminal 1
// Notes: terminals are inverted and registered, so fault_n_o and off_n_o are active low
`timescale 1ns/100ps
module dsos_relay_model #(
  parameter NUM_TERM = 5
) (
  input wire ref_clk_i,
  input wire [NUM_TERM-1:0] term_i,
  output reg fault_n_o,
  output reg off_n_o
);
  // ========
  // input stage
  always @(posedge ref_clk_i) begin
    fault_n_o <= ~term_i[0];
    off_n_o <= ~term_i[1];
  end
endmodule // dsos_relay_model

// File: testbench/dsos_status_select_asserts.sv
// Purpose: port-level checks of the status output selector
// Assumes: terminal 0 selector is tracked from register writes
// Notes: pin paths get a few cycles of synchroniser slack
`timescale 1ns/100ps
`include "dsos_defines.vh"
module dsos_checker #(
  parameter NUM_TERM = 5,
  parameter MISMATCH_CYC = 20
) (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire [`DSOS_ADDR_W-1:0] reg_addr_i,
  input wire [`DSOS_DATA_W-1:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire main_power_i,
  input wire safety_enable_a_i,
  input wire safety_enable_b_i,
  input wire alarm_mode_i,
  input wire [15:0] current_input_ua_i,
  input wire [NUM_TERM-1:0] term_o,
  input wire torque_cutoff_o,
  input wire enable_mismatch_trip_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // ========
  // helper state
  reg [7:0] sel0_q;
  reg [20:0] mm_cnt_q;
  wire mm_w = main_power_i && (safety_enable_a_i != safety_enable_b_i);
  // counter saturates so a long mismatch never wraps back under the limit
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel0_q <= 8'h00;
      mm_cnt_q <= 21'h000000;
    end else begin
      if (reg_wr_i && reg_addr_i == `DSOS_OFS_SEL_BASE)
        sel0_q <= reg_wdata_i[7:0];
      mm_cnt_q <= !mm_w ? 21'h000000 : mm_cnt_q + {20'h00000, !mm_cnt_q[20]};
    end
  end
  // ========
  // assertions
  a_any_fault_map:
    assert property ((sel0_q == 8'h63 && alarm_mode_i) [*3] |=> term_o[0])
    else $error("any-fault terminal not raised");
  a_wire_break_map:
    assert property ((sel0_q == 8'h3B && current_input_ua_i < 16'h07D0) [*3] |=> term_o[0])
    else $error("wire-break terminal not raised");
  a_unknown_code_off:
    assert property ((sel0_q == 8'hFF) [*3] |=> !term_o[0])
    else $error("unknown code drives terminal");
  a_mismatch_too_early:
    assert property ($rose(enable_mismatch_trip_o) |-> mm_cnt_q > MISMATCH_CYC)
    else $error("mismatch trip before limit");
  a_mismatch_missed:
    assert property (mm_cnt_q == MISMATCH_CYC + 10 |-> enable_mismatch_trip_o)
    else $error("mismatch trip missing");
  a_trip_stays_latched:
    assert property (enable_mismatch_trip_o |=> enable_mismatch_trip_o)
    else $error("mismatch trip cleared without restart");
  a_trip_cuts_torque:
    assert property (enable_mismatch_trip_o |-> torque_cutoff_o)
    else $error("output live while tripped");
  a_one_enable_cut:
    assert property (mm_w [*7] |-> torque_cutoff_o)
    else $error("output live with one enable");
  a_both_off_cut:
    assert property ((!safety_enable_a_i && !safety_enable_b_i) [*7] |-> torque_cutoff_o)
    else $error("output live with enables off");
  cover property ($rose(enable_mismatch_trip_o));
  cover property (sel0_q == 8'h63 && term_o[0]);
  cover property ($fell(torque_cutoff_o));
endmodule // dsos_checker

bind dsos_status_select dsos_checker #(
  .NUM_TERM(NUM_TERM),
  .MISMATCH_CYC(MISMATCH_CYC)
) i_dsos_checker (.*);

// File: testbench/dsos_status_select_tb.sv
// Purpose: self-checking bench for the status output selector
// Assumes: terminals 0 and 1 feed the relay model
// Notes: mismatch time shortened to keep the run brief
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module dsos_status_select_tb;
  localparam MM = 20;
  reg ref_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [15:0] reg_wdata_i = 16'h0000;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg main_power_i = 1'b0;
  reg safety_enable_a_i = 1'b0;
  reg safety_enable_b_i = 1'b0;
  reg run_cmd_i, ready_to_run_i, motor_overheat_i, fire_mode_i, light_alarm_i;
  reg alarm_mode_i, timer_op_ok_i, timer_cancel_i, second_loop_selected_i;
  reg [15:0] current_input_ua_i, run_time_i, start_count_i, out_freq_i, ref_freq_i;
  reg [3:0] timer_active_i;
  reg [1:0] loop_alarm_i, loop_feedback_err_i;
  reg [2:0] ext_loop_selected_i, ext_loop_duty_out_i, ext_loop_running_i;
  reg [2:0] ext_loop_alarm_i, ext_loop_feedback_err_i;
  wire [15:0] reg_rdata_o;
  wire [4:0] term_o;
  wire torque_cutoff_o, thermistor_trip_o, enable_mismatch_trip_o, fault_n, off_n;
  wire [3:0] en_view = {fault_n, off_n, torque_cutoff_o, enable_mismatch_trip_o};
  int err_total = 0;
  int cmp_count = 0;
  int i, k, m;
  reg [7:0] codes [18] = '{8'h37, 8'h38, 8'h3B, 8'h54, 8'h57, 8'h5F, 8'h62, 8'h63, 8'hBE,
    8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC};
  reg [23:0] rtab [9] = '{24'h110258, 24'h120000, 24'h130019, 24'h14FFFF, 24'h15FFFF,
    24'h100000, 24'h160008, 24'h200000, 24'h0400AB};
  // run, output freq, reference, expected {detected, arrival}
  reg [34:0] ftab [8] = '{{1'b1, 32'h02580300, 2'h0}, {1'b1, 32'h02590300, 2'h2},
    {1'b1, 32'h02480300, 2'h2}, {1'b1, 32'h02470300, 2'h0}, {1'b1, 32'h03190300, 2'h3},
    {1'b1, 32'h031A0300, 2'h2}, {1'b0, 32'h03000300, 2'h2}, {1'b1, 32'h00000000, 2'h0}};
  // power, enable a, enable b, expected {fault_n, off_n, cutoff}
  reg [5:0] ptab [7] = '{6'o37, 6'o45, 6'o76, 6'o63, 6'o76, 6'o53, 6'o76};
  dsos_status_select #(.NUM_TERM(5), .MISMATCH_CYC(MM)) i_dsos_status_select (.*);
  dsos_relay_model #(.NUM_TERM(5)) i_dsos_relay_model (.ref_clk_i(ref_clk_i),
    .term_i(term_o), .fault_n_o(fault_n), .off_n_o(off_n));
  initial forever #25 ref_clk_i = ~ref_clk_i;
  // ========
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_reg(input [7:0] a, input [15:0] d);
    @(posedge ref_clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input [7:0] a, input [15:0] msk, input [15:0] e);
    @(posedge ref_clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK("read data", e, reg_rdata_o & msk)
  endtask
  // idle state keeps the timer and external-loop alarm and feedback sources high so gating faults show up
  task automatic neutral();
    {run_cmd_i, ready_to_run_i, motor_overheat_i, fire_mode_i} <= 4'h0;
    {light_alarm_i, alarm_mode_i, timer_op_ok_i, second_loop_selected_i} <= 4'h0;
    {current_input_ua_i, run_time_i, start_count_i} <= 48'h07D001000100;
    {out_freq_i, ref_freq_i} <= 32'h00000300;
    {timer_active_i, timer_cancel_i, loop_alarm_i, loop_feedback_err_i} <= 9'h1F0;
    {ext_loop_selected_i, ext_loop_duty_out_i, ext_loop_running_i} <= 9'h000;
    {ext_loop_alarm_i, ext_loop_feedback_err_i} <= 6'h3F;
  endtask
  task automatic poke(input [7:0] c);
    k = (c - 8'hD3) / 10;
    m = (c - 8'hD3) % 10;
    case (c)
      8'h37: {run_cmd_i, ready_to_run_i} <= 2'h3;
      8'h38: motor_overheat_i <= 1'b1;
      8'h3B: current_input_ua_i <= 16'h07CF;
      8'h54: run_time_i <= 16'h0101;
      8'h57: {run_cmd_i, out_freq_i} <= 17'h10300;
      8'h5F: fire_mode_i <= 1'b1;
      8'h62: light_alarm_i <= 1'b1;
      8'h63: alarm_mode_i <= 1'b1;
      8'hBE: timer_op_ok_i <= 1'b1;
      8'hBF, 8'hC0, 8'hC1, 8'hC2: {timer_op_ok_i, timer_active_i} <= {1'b1, 4'h1 << (c - 8'hBF)};
      8'hC8: second_loop_selected_i <= 1'b1;
      8'hC9: loop_alarm_i <= 2'h1;
      8'hCA: loop_feedback_err_i <= 2'h1;
      8'hCB: loop_alarm_i <= 2'h2;
      8'hCC: loop_feedback_err_i <= 2'h2;
      default: case (m)
        0: ext_loop_selected_i <= 3'h1 << k;
        1: ext_loop_duty_out_i <= 3'h1 << k;
        2: ext_loop_running_i <= 3'h1 << k;
        3: {ext_loop_selected_i, ext_loop_feedback_err_i} <= {3'h1 << k, 3'h0};
        default: {ext_loop_selected_i, ext_loop_alarm_i} <= {3'h1 << k, 3'h0};
      endcase
    endcase
  endtask
  task automatic flag_case(input [7:0] c);
    neutral();
    wr_reg(8'h00, {8'h00, c});
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("flag idle", 1'b0, term_o[0])
    poke(c);
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("flag set", 1'b1, term_o[0])
    if (c == 8'h38)
      `CHK("thermistor trip", 1'b0, thermistor_trip_o)
  endtask
  // ========
  // main sequence
  initial begin
    neutral();
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1 `CHK("cutoff at reset", 1'b1, torque_cutoff_o)
    wr_reg(8'h16, 16'hFFFF);
    wr_reg(8'h20, 16'h1234);
    wr_reg(8'h04, 16'h00AB);
    for (i = 0; i < 9; i++)
      rd_chk(rtab[i][23:16], 16'hFFFF, rtab[i][15:0]);
    wr_reg(8'h00, 16'h00FF);
    alarm_mode_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 `CHK("unknown code", 2'b00, {term_o[4], term_o[0]})
    $display("test registers done");
    wr_reg(8'h10, 16'h0002);
    wr_reg(8'h14, 16'h0100);
    wr_reg(8'h15, 16'h0100);
    for (i = 0; i < 18; i++)
      flag_case(codes[i]);
    for (i = 0; i < 15; i++)
      flag_case(8'hD3 + 8'(10 * (i / 5) + i % 5));
    neutral();
    wr_reg(8'h00, 16'h0054);
    start_count_i <= 16'h0101;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("start count", 1'b1, term_o[0])
    $display("test flags done");
    wr_reg(8'h12, 16'h0010);
    for (i = 0; i < 8; i++) begin
      {run_cmd_i, out_freq_i, ref_freq_i} <= ftab[i][34:2];
      repeat (3) @(posedge ref_clk_i);
      rd_chk(8'h16, 16'h0030, {10'h000, ftab[i][1:0], 4'h0});
    end
    $display("test frequency done");
    wr_reg(8'h00, 16'h0038);
    wr_reg(8'h10, 16'h0001);
    motor_overheat_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("trip mode trip", 1'b1, thermistor_trip_o)
    `CHK("trip mode flag", 1'b0, term_o[0])
    rd_chk(8'h16, 16'h0080, 16'h0080);
    $display("test thermistor done");
    wr_reg(8'h00, 16'h0065);
    wr_reg(8'h01, 16'h0066);
    for (i = 0; i < 7; i++) begin
      {main_power_i, safety_enable_a_i, safety_enable_b_i} <= ptab[i][5:3];
      repeat (8) @(posedge ref_clk_i);
      #1 `CHK("enable view", {ptab[i][2:0], 1'b0}, en_view)
    end
    {main_power_i, safety_enable_a_i, safety_enable_b_i} <= 3'b110;
    repeat (MM + 15) @(posedge ref_clk_i);
    {main_power_i, safety_enable_a_i, safety_enable_b_i} <= 3'b111;
    repeat (8) @(posedge ref_clk_i);
    #1 `CHK("latched trip", 4'b0111, en_view)
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1 `CHK("trip after restart", 1'b0, enable_mismatch_trip_o)
    $display("test enables done");
    tally_and_finish();
  end
  // whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    $display("ERROR watchdog exp done got hang");
    tally_and_finish();
  end
endmodule // dsos_status_select_tb
